// *** core/ext_control_input_handler.sv ***
/*
  external control input handler: synchronises isolated control inputs,
  detects edges and issues measurement, zero, print and calibration pulses,
  plus panel lock gating; registers over AXI4-Lite.
  assumes inputs are asynchronous pins and the controller obeys hold times.
*/
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
// Summary of operation
// - trigger on selectable rising or falling edge
// - edge select resets to rising
// - external source: one edge, one measurement
// - internal source ignores trigger pin edges
// - each trigger updates statistics and memory
// - enter key and remote command also trigger
// - zero request rising edge: one adjustment
// - failed zero adjustment drives fault output
// - print request outputs current measured value
// - manual mode: cal rising edge starts calibration
// - auto mode ignores calibration request input
// - calibration lasts about 400 ms
// - cal during measurement waits for its end
// - panel lock disables keys except standby, enter
// - panel lock blocks unlock and remote cancel
`include "ext_ctrl_map.svh"
`timescale 1ns/1ns
`default_nettype none

module ext_control_input_handler
  import ext_ctrl_pkg::*;
#(
  parameter logic [31:0] CAL_CYCLES = 32'(`CAL_CYCLES)
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire ext_pins_t PINS_IN,
  input wire logic ENTER_KEY_IN,
  input wire logic REMOTE_TRIGGER_COMMAND_IN,
  input wire logic MEAS_BUSY_IN,
  input wire logic ZERO_DONE_IN,
  input wire logic ZERO_FAIL_IN,
  input wire logic [7:0] KEYS_IN,
  input wire logic UNLOCK_KEY_IN,
  input wire logic REMOTE_CANCEL_IN,
  output logic MEAS_START_OUT,
  output logic STATS_UPDATE_OUT,
  output logic ZERO_START_OUT,
  output logic PRINT_OUT,
  output logic CAL_START_OUT,
  output logic CAL_BUSY_OUT,
  output logic MEAS_FAULT_OUT,
  output logic [7:0] KEYS_OUT,
  output logic UNLOCK_OUT,
  output logic REMOTE_CANCEL_OUT,
  output logic IRQ_OUT,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  localparam int KEY_STANDBY = 0;
  localparam int KEY_ENTER = 1;

  //////////////////////////////////////////////////////////////////////////
  // synchronisers and edge history
  ext_pins_t sync1_reg, sync2_reg, hist_reg;

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      hist_reg <= '0;
    end else begin
      sync1_reg <= PINS_IN;
      sync2_reg <= sync1_reg;
      hist_reg <= sync2_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control registers
  logic [31:0] ctrl_reg, ctrl_next;
  logic [`IRQ_WIDTH-1:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
  logic edge_fall, src_internal, cal_auto;
  assign edge_fall = ctrl_reg[`CTRL_EDGE_BIT];
  assign src_internal = ctrl_reg[`CTRL_SRC_BIT];
  assign cal_auto = ctrl_reg[`CTRL_CALAUTO_BIT];

  //////////////////////////////////////////////////////////////////////////
  // event decode
  logic measure_request_in_rise, measure_request_in_fall, pin_trigger, any_trigger, zero_edge, print_edge, cal_edge;
  assign measure_request_in_rise = sync2_reg.measure_request & ~hist_reg.measure_request;
  assign measure_request_in_fall = ~sync2_reg.measure_request & hist_reg.measure_request;
  assign pin_trigger = ~src_internal & (edge_fall ? measure_request_in_fall : measure_request_in_rise);
  assign any_trigger = pin_trigger | ENTER_KEY_IN | REMOTE_TRIGGER_COMMAND_IN;
  assign zero_edge = sync2_reg.zero_offset_request & ~hist_reg.zero_offset_request;
  assign print_edge = sync2_reg.print_request & ~hist_reg.print_request;
  assign cal_edge = ~cal_auto & sync2_reg.cal_request & ~hist_reg.cal_request;

  //////////////////////////////////////////////////////////////////////////
  // calibration sequencer
  cal_state_t cal_state_reg, cal_state_next;
  logic [31:0] cal_cnt_reg, cal_cnt_next;
  logic cal_start, cal_done;

  always_comb begin
    cal_state_next = cal_state_reg;
    cal_cnt_next = cal_cnt_reg;
    cal_start = 1'b0;
    cal_done = 1'b0;
    case (cal_state_reg)
      CAL_IDLE: begin
        if (cal_edge) begin
          if (MEAS_BUSY_IN) begin
            cal_state_next = CAL_WAIT;
          end else begin
            cal_start = 1'b1;
            cal_cnt_next = CAL_CYCLES;
            cal_state_next = CAL_RUN;
          end
        end
      end
      CAL_WAIT: begin
        if (!MEAS_BUSY_IN) begin
          cal_start = 1'b1;
          cal_cnt_next = CAL_CYCLES;
          cal_state_next = CAL_RUN;
        end
      end
      CAL_RUN: begin
        if (cal_cnt_reg <= 32'h0000_0001) begin
          cal_done = 1'b1;
          cal_cnt_next = '0;
          cal_state_next = CAL_IDLE;
        end else begin
          cal_cnt_next = cal_cnt_reg - 32'h0000_0001;
        end
      end
      default: begin
        cal_state_next = CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cal_state_reg <= CAL_IDLE;
      cal_cnt_reg <= '0;
    end else begin
      cal_state_reg <= cal_state_next;
      cal_cnt_reg <= cal_cnt_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // action outputs and fault
  logic fault_reg, fault_next;
  logic zfail_clr;
  logic [7:0] keys_next;

  always_comb begin
    fault_next = fault_reg;
    if (zfail_clr) begin
      fault_next = 1'b0;
    end
    if (ZERO_FAIL_IN) begin
      fault_next = 1'b1;
    end
    keys_next = KEYS_IN;
    if (sync2_reg.key_lock) begin
      keys_next = KEYS_IN & ((8'h01 << KEY_STANDBY) | (8'h01 << KEY_ENTER));
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      MEAS_START_OUT <= 1'b0;
      STATS_UPDATE_OUT <= 1'b0;
      ZERO_START_OUT <= 1'b0;
      PRINT_OUT <= 1'b0;
      CAL_START_OUT <= 1'b0;
      CAL_BUSY_OUT <= 1'b0;
      fault_reg <= 1'b0;
      KEYS_OUT <= '0;
      UNLOCK_OUT <= 1'b0;
      REMOTE_CANCEL_OUT <= 1'b0;
    end else begin
      MEAS_START_OUT <= any_trigger;
      STATS_UPDATE_OUT <= any_trigger;
      ZERO_START_OUT <= zero_edge;
      PRINT_OUT <= print_edge;
      CAL_START_OUT <= cal_start;
      CAL_BUSY_OUT <= (cal_state_next == CAL_RUN);
      fault_reg <= fault_next;
      KEYS_OUT <= keys_next;
      UNLOCK_OUT <= UNLOCK_KEY_IN & ~sync2_reg.key_lock;
      REMOTE_CANCEL_OUT <= REMOTE_CANCEL_IN & ~sync2_reg.key_lock;
    end
  end
  assign MEAS_FAULT_OUT = fault_reg;

  //////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [3:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_next, arready_next, rvalid_next;
  logic [1:0] bresp_next, rresp_next;
  logic [31:0] rdata_next, rd_word, wr_word;
  logic do_write, do_read, stat_rd_clr;
  logic [`IRQ_WIDTH-1:0] events;

  assign events = {ZERO_FAIL_IN, cal_done, print_edge, ZERO_DONE_IN, any_trigger};

  always_comb begin
    aw_hold_next = aw_hold_reg;
    w_hold_next = w_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_hold_next = 1'b1;
      aw_addr_next = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_hold_next = 1'b1;
      w_data_next = S_AXI_WDATA;
      w_strb_next = S_AXI_WSTRB;
    end
    do_write = aw_hold_reg && w_hold_reg && !S_AXI_BVALID;
    if (do_write) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
    end
    bvalid_next = S_AXI_BVALID & ~S_AXI_BREADY;
    bresp_next = S_AXI_BRESP;
    if (do_write) begin
      bvalid_next = 1'b1;
      bresp_next = (aw_addr_reg[1:0] == 2'h0) ? 2'h0 : 2'h2;
    end
    do_read = S_AXI_ARVALID && S_AXI_ARREADY;
    arready_next = ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
    rvalid_next = S_AXI_RVALID & ~S_AXI_RREADY;
    rdata_next = S_AXI_RDATA;
    rresp_next = S_AXI_RRESP;
    rd_word = '0;
    stat_rd_clr = 1'b0;
    case (S_AXI_ARADDR)
      `OFF_CTRL: rd_word = ctrl_reg;
      `OFF_STATUS: rd_word = {26'h000_0000, sync2_reg.key_lock, fault_reg,
                              (cal_state_reg == CAL_WAIT), CAL_BUSY_OUT,
                              MEAS_BUSY_IN, src_internal};
      `OFF_IRQ_STAT: begin
        rd_word = {27'h000_0000, irq_stat_reg};
        stat_rd_clr = do_read;
      end
      `OFF_IRQ_MASK: rd_word = {27'h000_0000, irq_mask_reg};
      default: rd_word = '0;
    endcase
    if (do_read) begin
      rvalid_next = 1'b1;
      rdata_next = rd_word;
      rresp_next = (S_AXI_ARADDR[1:0] == 2'h0) ? 2'h0 : 2'h2;
    end
    wr_word = ctrl_reg;
    for (int i = 0; i < 4; i++) begin
      if (w_strb_reg[i]) begin
        wr_word[i*8 +: 8] = w_data_reg[i*8 +: 8];
      end
    end
    ctrl_next = ctrl_reg;
    irq_mask_next = irq_mask_reg;
    zfail_clr = 1'b0;
    if (do_write && aw_addr_reg == `OFF_CTRL) begin
      ctrl_next = {29'h0000_0000, wr_word[2:0]};
      zfail_clr = wr_word[`CTRL_ZFAIL_CLR_BIT];
    end
    if (do_write && aw_addr_reg == `OFF_IRQ_MASK) begin
      irq_mask_next = w_strb_reg[0] ? w_data_reg[`IRQ_WIDTH-1:0] : irq_mask_reg;
    end
    irq_stat_next = (stat_rd_clr ? '0 : irq_stat_reg) | events;
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'h0;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= 2'h0;
      ctrl_reg <= `CTRL_RESET;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      IRQ_OUT <= 1'b0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      S_AXI_AWREADY <= ~aw_hold_next & ~S_AXI_AWREADY & S_AXI_AWVALID;
      S_AXI_WREADY <= ~w_hold_next & ~S_AXI_WREADY & S_AXI_WVALID;
      S_AXI_BVALID <= bvalid_next;
      S_AXI_BRESP <= bresp_next;
      S_AXI_ARREADY <= arready_next;
      S_AXI_RVALID <= rvalid_next;
      S_AXI_RDATA <= rdata_next;
      S_AXI_RRESP <= rresp_next;
      ctrl_reg <= ctrl_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      IRQ_OUT <= |(irq_stat_next & irq_mask_next);
    end
  end

endmodule

`default_nettype wire

// *** core/ext_ctrl_map.svh ***
/*
  constants for the external control input handler: register offsets,
  field positions, reset values and timing counts.
  assumes a 50 MHz system clock and 32-bit AXI4-Lite word registers.
*/
`ifndef EXT_CTRL_MAP_SVH
`define EXT_CTRL_MAP_SVH

`define CLK_HZ 50_000_000
`define CAL_TIME_MS 400
`define CAL_CYCLES ((`CAL_TIME_MS * 64'(`CLK_HZ)) / 64'd1000)

`define OFF_CTRL 4'h0
`define OFF_STATUS 4'h4
`define OFF_IRQ_STAT 4'h8
`define OFF_IRQ_MASK 4'hC

`define CTRL_EDGE_BIT 0
`define CTRL_SRC_BIT 1
`define CTRL_CALAUTO_BIT 2
`define CTRL_ZFAIL_CLR_BIT 3
`define CTRL_RESET 32'h0000_0002

`define IRQ_MEASURE_REQUEST_IN_BIT 0
`define IRQ_ZERO_BIT 1
`define IRQ_PRINT_BIT 2
`define IRQ_CALDONE_BIT 3
`define IRQ_ZFAIL_BIT 4
`define IRQ_WIDTH 5

`endif

// *** core/ext_ctrl_pkg.sv ***
/*
  types for the external control input handler.
  assumes ext_ctrl_map.svh holds all numbers.
*/
package ext_ctrl_pkg;
  typedef struct packed {
    logic measure_request;
    logic zero_offset_request;
    logic print_request;
    logic cal_request;
    logic key_lock;
  } ext_pins_t;

  typedef enum logic [1:0] {CAL_IDLE, CAL_WAIT, CAL_RUN} cal_state_t;
endpackage

// *** tb/ext_control_input_handler_tb_top.sv ***
/* testbench: corner and random tests of the handler.
   assumes controller model on the pins, bench as bus master. */
`timescale 1ns/1ns
`default_nettype none
`include "ext_ctrl_map.svh"
module ext_control_input_handler_tb_top;
  import ext_ctrl_pkg::*;
  localparam int HOLD = 8; // scaled request hold
  logic CLK_IN = 1'h0, RST_N_IN = 1'h0, ENTER_KEY_IN = 1'h0, REMOTE_TRIGGER_COMMAND_IN = 1'h0;
  logic MEAS_BUSY_IN = 1'h0, ZERO_DONE_IN = 1'h0, ZERO_FAIL_IN = 1'h0, UNLOCK_KEY_IN = 1'h0;
  logic REMOTE_CANCEL_IN = 1'h0, lock = 1'h0, fail_mode = 1'h0, S_AXI_AWVALID = 1'h0;
  logic S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0, S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
  logic MEAS_START_OUT, STATS_UPDATE_OUT, ZERO_START_OUT, PRINT_OUT, CAL_START_OUT;
  logic CAL_BUSY_OUT, MEAS_FAULT_OUT, UNLOCK_OUT, REMOTE_CANCEL_OUT, IRQ_OUT, S_AXI_AWREADY;
  logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [7:0] KEYS_IN = 8'h00, KEYS_OUT;
  logic [3:0] S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0, S_AXI_WSTRB = 4'hf, fire = 4'h0;
  logic [31:0] S_AXI_WDATA = 32'h0000_0000, S_AXI_RDATA, rd_data, seed = 32'h0000_4a14;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
  ext_pins_t PINS_IN;
  int err_total = 0, num_checks = 0, cyc = 0, f_cyc = 0, st_cyc = 0;
  int ev[4] = '{default: 0};
  int b[4];
  always #10 CLK_IN = ~CLK_IN;
  ext_control_input_handler #(.CAL_CYCLES(32'h0000_0014)) DUT (.CLK_IN, .RST_N_IN, .PINS_IN,
    .ENTER_KEY_IN, .REMOTE_TRIGGER_COMMAND_IN, .MEAS_BUSY_IN, .ZERO_DONE_IN, .ZERO_FAIL_IN,
    .KEYS_IN, .UNLOCK_KEY_IN, .REMOTE_CANCEL_IN, .MEAS_START_OUT, .STATS_UPDATE_OUT,
    .ZERO_START_OUT, .PRINT_OUT, .CAL_START_OUT, .CAL_BUSY_OUT, .MEAS_FAULT_OUT, .KEYS_OUT,
    .UNLOCK_OUT, .REMOTE_CANCEL_OUT, .IRQ_OUT, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY);
  ext_ctrl_controller #(.HOLD(HOLD)) u_ctl (.clk_in(CLK_IN), .rst_n_in(RST_N_IN),
    .fire_in(fire), .lock_in(lock), .pins_out(PINS_IN));
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge CLK_IN) begin
    cyc <= cyc + 1;
    ZERO_DONE_IN <= ZERO_START_OUT && !fail_mode;
    ZERO_FAIL_IN <= ZERO_START_OUT && fail_mode;
    if (MEAS_START_OUT === 1'h1) begin
      ev[0] <= ev[0] + 1;
      st_cyc <= cyc;
    end
    if (ZERO_START_OUT === 1'h1) ev[1] <= ev[1] + 1;
    if (PRINT_OUT === 1'h1) ev[2] <= ev[2] + 1;
    if (CAL_START_OUT === 1'h1) ev[3] <= ev[3] + 1;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] keys_exp(input logic [7:0] k, input logic l);
    return l ? (k & 8'h03) : k;
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic to();
    $display("[ERR] wait limit exp done got hang");
    err_total++;
    test_done();
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", n, e, g);
      err_total++;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge CLK_IN);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    int n;
    @(posedge CLK_IN);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(negedge CLK_IN);
      ha = S_AXI_AWREADY && S_AXI_AWVALID;
      hw = S_AXI_WREADY && S_AXI_WVALID;
      hb = S_AXI_BVALID;
      resp = S_AXI_BRESP;
      @(posedge CLK_IN);
      if (ha) S_AXI_AWVALID <= 1'h0;
      if (hw) S_AXI_WVALID <= 1'h0;
      if (hb) break;
    end
    S_AXI_BREADY <= 1'h0;
    if (n == 40) to();
  endtask
  task automatic rd(input logic [3:0] a);
    logic ha, hb;
    int n;
    @(posedge CLK_IN);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(negedge CLK_IN);
      ha = S_AXI_ARREADY && S_AXI_ARVALID;
      hb = S_AXI_RVALID;
      rd_data = S_AXI_RDATA;
      resp = S_AXI_RRESP;
      @(posedge CLK_IN);
      if (ha) S_AXI_ARVALID <= 1'h0;
      if (hb) break;
    end
    S_AXI_RREADY <= 1'h0;
    if (n == 40) to();
  endtask
  task automatic pulse(input int i);
    @(posedge CLK_IN);
    fire[i] <= 1'h1;
    @(posedge CLK_IN);
    fire[i] <= 1'h0;
    f_cyc = cyc;
    repeat (2 * HOLD + 12) @(posedge CLK_IN);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    idle(2);
    RST_N_IN <= 1'h1;
    rd(`OFF_CTRL);
    chk("ctrl reset", `CTRL_RESET, rd_data);
    rd(4'h2);
    chk("misaligned resp", 2'h2, resp);
    b = ev;
    for (int i = 3; i >= 0; i--) pulse(i);
    idle(10);
    chk("internal starts", 0, ev[0] - b[0]);
    chk("zero runs", 1, ev[1] - b[1]);
    chk("prints", 1, ev[2] - b[2]);
    chk("cal runs", 1, ev[3] - b[3]);
    chk("irq masked", 0, IRQ_OUT);
    wr(`OFF_IRQ_MASK, 32'h0000_001f);
    idle(3);
    chk("irq raised", 1, IRQ_OUT);
    rd(`OFF_IRQ_STAT);
    chk("irq status", 32'h0000_000e, rd_data);
    idle(3);
    chk("irq cleared", 0, IRQ_OUT);
    $display("test internal done");
    for (int e = 0; e < 2; e++) begin
      wr(`OFF_CTRL, 32'(e));
      b = ev;
      pulse(3);
      chk("pin starts", 1, ev[0] - b[0]);
      chk("late edge", 32'(e), 32'((st_cyc - f_cyc) > HOLD));
    end
    b = ev;
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      wr(`OFF_CTRL, {30'h0000_0000, seed[1], 1'h0});
      ENTER_KEY_IN <= seed[0];
      REMOTE_TRIGGER_COMMAND_IN <= !seed[0];
      @(posedge CLK_IN);
      ENTER_KEY_IN <= 1'h0;
      REMOTE_TRIGGER_COMMAND_IN <= 1'h0;
      idle(2);
    end
    chk("key starts", 8, ev[0] - b[0]);
    $display("test trigger done");
    fail_mode = 1'h1;
    pulse(2);
    chk("fault set", 1, MEAS_FAULT_OUT);
    rd(`OFF_STATUS);
    chk("status", {27'h000_0000, 1'h1, 3'h0, seed[1]}, rd_data);
    wr(`OFF_CTRL, 32'h0000_0008);
    idle(2);
    chk("fault clear", 0, MEAS_FAULT_OUT);
    MEAS_BUSY_IN <= 1'h1;
    b = ev;
    pulse(0);
    chk("cal held", 0, ev[3] - b[3]);
    MEAS_BUSY_IN <= 1'h0;
    idle(4);
    chk("cal after meas", 1, ev[3] - b[3]);
    idle(30);
    wr(`OFF_CTRL, 32'h0000_0004);
    b = ev;
    pulse(0);
    chk("auto cal", 0, ev[3] - b[3]);
    $display("test zero cal done");
    for (int l = 0; l < 2; l++) begin
      seed = lfsr(seed);
      lock <= l[0];
      KEYS_IN <= seed[7:0];
      UNLOCK_KEY_IN <= 1'h1;
      REMOTE_CANCEL_IN <= 1'h1;
      idle(8);
      chk("keys", 32'(keys_exp(seed[7:0], l[0])), 32'(KEYS_OUT));
      chk("unlock", 32'(!l[0]), 32'(UNLOCK_OUT));
      chk("remote cancel", 32'(!l[0]), 32'(REMOTE_CANCEL_OUT));
    end
    $display("test lock done");
    test_done();
  end
endmodule
`default_nettype wire

// *** tb/ext_ctrl_checker_assertions.sv ***
/* checker: port assertions for the control input handler.
   assumes binding into ext_control_input_handler. */
`timescale 1ns/1ns
`default_nettype none
module ext_ctrl_checker
  import ext_ctrl_pkg::*;
#(parameter logic [31:0] CAL_CYCLES = 32'h0000_0014) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire ext_pins_t PINS_IN,
  input wire logic ENTER_KEY_IN,
  input wire logic REMOTE_TRIGGER_COMMAND_IN,
  input wire logic MEAS_BUSY_IN,
  input wire logic ZERO_FAIL_IN,
  input wire logic MEAS_START_OUT,
  input wire logic STATS_UPDATE_OUT,
  input wire logic ZERO_START_OUT,
  input wire logic PRINT_OUT,
  input wire logic CAL_START_OUT,
  input wire logic CAL_BUSY_OUT,
  input wire logic MEAS_FAULT_OUT,
  input wire logic [7:0] KEYS_OUT,
  input wire logic UNLOCK_OUT,
  input wire logic REMOTE_CANCEL_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic [31:0] busy_reg;
  logic [31:0] busy_next;
  always_comb busy_next = CAL_BUSY_OUT ? busy_reg + 32'h0000_0001 : 32'h0000_0000;
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) busy_reg <= 32'h0000_0000;
    else busy_reg <= busy_next;
  end
  //////////////////////////////////////////////////////////////////////////////
  a_stats_follow: assert property (MEAS_START_OUT == STATS_UPDATE_OUT)
    else $error("stats pulse apart from start");
  a_key_start: assert property ((ENTER_KEY_IN || REMOTE_TRIGGER_COMMAND_IN) |=> MEAS_START_OUT)
    else $error("no start after key");
  a_zero_once: assert property ($rose(PINS_IN.zero_offset_request) |-> ##[3:5] ZERO_START_OUT ##1 !ZERO_START_OUT)
    else $error("zero start missing or long");
  a_fault_set: assert property (ZERO_FAIL_IN |=> MEAS_FAULT_OUT)
    else $error("fault not raised");
  a_print_edge: assert property ($rose(PINS_IN.print_request) |-> ##[3:5] PRINT_OUT)
    else $error("print pulse missing");
  a_cal_length: assert property ($fell(CAL_BUSY_OUT) |-> busy_reg == CAL_CYCLES)
    else $error("cal busy length wrong");
  a_cal_after_meas: assert property (CAL_START_OUT |-> !$past(MEAS_BUSY_IN))
    else $error("cal start during measurement");
  a_lock_gate: assert property (PINS_IN.key_lock [*5] |-> KEYS_OUT[7:2] == 6'h00 && !UNLOCK_OUT && !REMOTE_CANCEL_OUT)
    else $error("locked keys passed");
endmodule
bind ext_control_input_handler ext_ctrl_checker #(.CAL_CYCLES(CAL_CYCLES)) u_chk (.CLK_IN,
  .RST_N_IN, .PINS_IN, .ENTER_KEY_IN, .REMOTE_TRIGGER_COMMAND_IN, .MEAS_BUSY_IN, .ZERO_FAIL_IN,
  .MEAS_START_OUT, .STATS_UPDATE_OUT, .ZERO_START_OUT, .PRINT_OUT, .CAL_START_OUT,
  .CAL_BUSY_OUT, .MEAS_FAULT_OUT, .KEYS_OUT, .UNLOCK_OUT, .REMOTE_CANCEL_OUT);
`default_nettype wire

// *** tb/ext_ctrl_controller.sv ***
/* controller model: drives the isolated request pins.
   assumes fire requests only after the previous pulse ended. */
`timescale 1ns/1ns
`default_nettype none
module ext_ctrl_controller
  import ext_ctrl_pkg::*;
#(parameter int HOLD = 8) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] fire_in,
  input wire logic lock_in,
  output wire ext_pins_t pins_out
);
  for (genvar i = 0; i < 4; i++) begin : g_ch
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    always_comb begin
      cnt_next = cnt_reg;
      if (cnt_reg != 8'h00) cnt_next = cnt_reg - 8'h01;
      else if (fire_in[i]) cnt_next = 8'(2 * HOLD);
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) cnt_reg <= 8'h00;
      else cnt_reg <= cnt_next;
    end
    assign pins_out[i + 1] = cnt_reg > 8'(HOLD);
  end
  assign pins_out[0] = lock_in;
endmodule
`default_nettype wire
